// ===== fflg_cfg.svh
`ifndef FFLG_CFG_SVH
`define FFLG_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets on the wishbone slave
// ---------------------------------------------------------------
`define FFLG_OFS_THRESH  8'h00
`define FFLG_OFS_LEVEL   8'h04
`define FFLG_OFS_FLAGS   8'h08
`define FFLG_OFS_IRQ_ST  8'h0c
`define FFLG_OFS_IRQ_MSK 8'h10
`define FFLG_OFS_CTRL    8'h14
// ---------------------------------------------------------------
// field layouts and reset values
// ---------------------------------------------------------------
`define FFLG_UPPER_LSB   8
`define FFLG_LOWER_LSB   0
`define FFLG_THR_RST     8'h00
`define FFLG_CTRL_CLR    0
`define FFLG_CTRL_DEPTH_LSB 4
`define FFLG_DEPTH_RST   3'h0
`define FFLG_LEVEL_W     16
`define FFLG_THR_W       8
`define FFLG_LOW_PAD     8'h00
`define FFLG_IRQ_W       4
`define FFLG_IRQ_FULL    0
`define FFLG_IRQ_EMPTY   1
`define FFLG_IRQ_UPPER   2
`define FFLG_IRQ_LOWER   3
`define FFLG_BASE_BITS   4'h4
`endif

// ===== fflg_pkg.sv
`default_nettype none
package fflg_pkg;
  // cascade depth code: 1, 2, 4, 8 or 16 blocks deep
  typedef logic [2:0] fflg_depth_t;
  typedef enum logic [1:0] {
    FFLG_BUS_IDLE,
    FFLG_BUS_ACK
  } fflg_bus_e;
endpackage
`default_nettype wire

// ===== fflg_compare.sv
`include "fflg_cfg.svh"
`default_nettype none
// ---------------------------------------------------------------
// threshold comparators on the fill level against the masked thresholds
// ---------------------------------------------------------------
module fflg_compare #(
  parameter int LW = 16,
  parameter int TW = 8
) (
  input  wire logic [LW-1:0]          level_i,
  input  wire logic [TW-1:0]          upper_threshold_i,
  input  wire logic [TW-1:0]          lower_threshold_i,
  input  wire fflg_pkg::fflg_depth_t  depth_i,
  output logic                        upper_mark_flag_o,
  output logic                        lower_mark_flag_o
);
  logic [TW-1:0] thr_mask;
  logic [TW-1:0] up_m;
  logic [TW-1:0] lo_m;

  // usable threshold bits: 4 plus depth code, counted from the bottom;
  // a shallow fifo never sets the top fill-level bits, so those are cut
  always_comb begin
    thr_mask = '1;
    for (int i = 0; i < TW; i++) begin
      if (i >= (int'(`FFLG_BASE_BITS) + int'(depth_i)))
        thr_mask[i] = 1'b0;
    end
    up_m = upper_threshold_i & thr_mask;
    lo_m = lower_threshold_i & thr_mask;
  end

  // compare against the threshold in the top byte, low byte zero
  assign upper_mark_flag_o = (level_i >= {up_m, `FFLG_LOW_PAD});
  assign lower_mark_flag_o = ({lo_m, `FFLG_LOW_PAD} >= level_i);
endmodule // fflg_compare
`default_nettype wire

// ===== fflg_top.sv
`include "fflg_cfg.svh"
`default_nettype none
module fflg_top #(
  parameter int LW = `FFLG_LEVEL_W,
  parameter int TW = `FFLG_THR_W,
  parameter int CAP = 65535
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone classic slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  // user fifo side
  input  wire logic          fifo_clear_in_i,
  input  wire logic          wr_req_i,
  input  wire logic          rd_req_i,
  output logic               rd_word_o,
  output logic               full_o,
  output logic               empty_o,
  output logic               near_full_status_o,
  output logic               near_empty_status_o,
  output logic [LW-1:0]      fill_level_o,
  output logic               irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [LW-1:0]            level_r, level_nxt;
  logic                     rdw_r, rdw_nxt;
  logic                     full_r, full_nxt;
  logic                     empty_r, empty_nxt;
  logic                     nf_r, nf_nxt;
  logic                     ne_r, ne_nxt;
  logic [TW-1:0]            upth_r, upth_nxt;
  logic [TW-1:0]            loth_r, loth_nxt;
  fflg_pkg::fflg_depth_t    depth_r, depth_nxt;
  logic                     sclr_r, sclr_nxt;
  logic [`FFLG_IRQ_W-1:0]   ist_r, ist_nxt;
  logic [`FFLG_IRQ_W-1:0]   imsk_r, imsk_nxt;
  logic                     irq_r, irq_nxt;
  logic [31:0]              dat_r, dat_nxt;
  fflg_pkg::fflg_bus_e      bus_r, bus_nxt;
  logic                     up_flag;
  logic                     lo_flag;
  logic                     clr;
  logic                     wr_acc;
  logic                     rd_acc;
  logic [LW-1:0]            level_next_val;
  logic                     bus_req;
  logic                     bus_wr;
  logic                     bus_rd;
  logic [`FFLG_IRQ_W-1:0]   ev;

  // ---------------------------------------------------------------
  // comparators on the next level so flags track the count
  // ---------------------------------------------------------------
  fflg_compare #(
    .LW (LW),
    .TW (TW)
  ) u_cmp (
    .level_i           (level_next_val),
    .upper_threshold_i (upth_r),
    .lower_threshold_i (loth_r),
    .depth_i           (depth_r),
    .upper_mark_flag_o (up_flag),
    .lower_mark_flag_o (lo_flag)
  );

  // ---------------------------------------------------------------
  // fill level and flags
  // ---------------------------------------------------------------
  // clear from the pin or from software; both are same-clock logic
  assign clr    = fifo_clear_in_i | sclr_r;
  // reads gated by empty; writes gated by full so the count never wraps
  assign rd_acc = rd_req_i & ~empty_r;
  assign wr_acc = wr_req_i & ~full_r;

  always_comb begin
    level_next_val = level_r;
    if (clr)
      level_next_val = '0;
    else if (wr_acc && !rd_acc)
      level_next_val = level_r + 1'b1;
    else if (rd_acc && !wr_acc)
      level_next_val = level_r - 1'b1;
  end

  always_comb begin
    level_nxt = level_next_val;
    rdw_nxt   = rd_acc & ~clr;
    full_nxt  = (level_next_val == LW'(CAP));
    empty_nxt = (level_next_val == '0);
    nf_nxt    = up_flag;
    ne_nxt    = lo_flag;
    if (clr) begin
      full_nxt  = 1'b0;
      nf_nxt    = 1'b0;
      empty_nxt = 1'b1;
      ne_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= '0;
      rdw_r   <= 1'b0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
      nf_r    <= 1'b0;
      ne_r    <= 1'b1;
    end else begin
      level_r <= level_nxt;
      rdw_r   <= rdw_nxt;
      full_r  <= full_nxt;
      empty_r <= empty_nxt;
      nf_r    <= nf_nxt;
      ne_r    <= ne_nxt;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave and registers
  // ---------------------------------------------------------------
  // one wait state: ack in the cycle after the request is seen
  assign bus_req = cyc_i & stb_i & (bus_r == fflg_pkg::FFLG_BUS_IDLE);
  assign bus_wr  = bus_req & we_i;
  assign bus_rd  = bus_req & ~we_i;
  // edges of the flags as they will be registered: a clear that holds
  // the upper mark down must not log an upper-mark event
  assign ev      = {ne_nxt & ~ne_r, nf_nxt & ~nf_r,
                    empty_nxt & ~empty_r, full_nxt & ~full_r};

  always_comb begin
    bus_nxt  = bus_req ? fflg_pkg::FFLG_BUS_ACK : fflg_pkg::FFLG_BUS_IDLE;
    upth_nxt = upth_r;
    loth_nxt = loth_r;
    depth_nxt = depth_r;
    sclr_nxt = 1'b0;
    imsk_nxt = imsk_r;
    dat_nxt  = '0;
    ist_nxt  = ist_r;
    if (bus_wr) begin
      unique case (adr_i)
        `FFLG_OFS_THRESH: begin
          if (sel_i[0]) loth_nxt = dat_i[`FFLG_LOWER_LSB +: TW];
          if (sel_i[1]) upth_nxt = dat_i[`FFLG_UPPER_LSB +: TW];
        end
        `FFLG_OFS_IRQ_MSK: begin
          if (sel_i[0]) imsk_nxt = dat_i[`FFLG_IRQ_W-1:0];
        end
        `FFLG_OFS_CTRL: begin
          if (sel_i[0]) begin
            sclr_nxt  = dat_i[`FFLG_CTRL_CLR];
            depth_nxt = dat_i[`FFLG_CTRL_DEPTH_LSB +: 3];
          end
        end
        default: ;
      endcase
    end
    if (bus_rd) begin
      unique case (adr_i)
        `FFLG_OFS_THRESH:
          dat_nxt = 32'({upth_r, loth_r});
        `FFLG_OFS_LEVEL:
          dat_nxt = 32'(level_r);
        `FFLG_OFS_FLAGS:
          dat_nxt = 32'({ne_r, nf_r, empty_r, full_r});
        `FFLG_OFS_IRQ_ST: begin
          dat_nxt = 32'(ist_r);
          ist_nxt = '0; // read clears
        end
        `FFLG_OFS_IRQ_MSK:
          dat_nxt = 32'(imsk_r);
        `FFLG_OFS_CTRL:
          dat_nxt = 32'({depth_r, 4'h0});
        default: dat_nxt = '0; // unmapped reads zero, still acked
      endcase
    end
    // set wins over the read clear
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r   <= fflg_pkg::FFLG_BUS_IDLE;
      upth_r  <= `FFLG_THR_RST;
      loth_r  <= `FFLG_THR_RST;
      depth_r <= `FFLG_DEPTH_RST;
      sclr_r  <= 1'b0;
      imsk_r  <= '0;
      ist_r   <= '0;
      irq_r   <= 1'b0;
      dat_r   <= '0;
    end else begin
      bus_r   <= bus_nxt;
      upth_r  <= upth_nxt;
      loth_r  <= loth_nxt;
      depth_r <= depth_nxt;
      sclr_r  <= sclr_nxt;
      imsk_r  <= imsk_nxt;
      ist_r   <= ist_nxt;
      irq_r   <= irq_nxt;
      dat_r   <= dat_nxt;
    end
  end

  // outputs straight from flip-flops
  assign ack_o               = (bus_r == fflg_pkg::FFLG_BUS_ACK);
  assign dat_o               = dat_r;
  assign rd_word_o           = rdw_r;
  assign full_o              = full_r;
  assign empty_o             = empty_r;
  assign near_full_status_o  = nf_r;
  assign near_empty_status_o = ne_r;
  assign fill_level_o        = level_r;
  assign irq_o               = irq_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_clear;
    clr;
  endsequence

  chk_clear_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    s_clear |=> (empty_o && near_empty_status_o && !full_o
                 && !near_full_status_o && fill_level_o == '0))
    else $error("clear did not force empty state");

  chk_level_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clr && wr_acc && !rd_acc) |=> fill_level_o == $past(level_r) + 1'b1)
    else $error("fill level did not increment");

  chk_level_dec: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clr && rd_acc && !wr_acc) |=> fill_level_o == $past(level_r) - 1'b1)
    else $error("fill level did not decrement");

  chk_read_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req_i && empty_o) |=> !rd_word_o)
    else $error("read word while empty");

  chk_read_word: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_req_i && !empty_o && !clr) |=> rd_word_o)
    else $error("valid read gave no word");

  chk_upper_mark: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(clr) && !$past(rst_i) && $stable(upth_r) && $stable(depth_r)
     && fill_level_o >= {upth_r, `FFLG_LOW_PAD}) |-> near_full_status_o)
    else $error("upper mark missing");

  chk_lower_mark: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(clr) == 1'b0 && $stable(loth_r) && depth_r == 3'h4
     && {loth_r, `FFLG_LOW_PAD} < fill_level_o) |-> !near_empty_status_o)
    else $error("lower mark wrongly high");

  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus ack not single one-cycle pulse");

  // read data stands only with ack; the bus sees zero otherwise
  chk_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == '0)
    else $error("read data outside ack");

  // a write offered while full is dropped; a read alongside would move it
  sequence s_write_refused;
    wr_req_i && full_o && !rd_req_i && !clr;
  endsequence

  chk_full_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_refused |=> fill_level_o == $past(fill_level_o))
    else $error("write accepted while full");

  // simultaneous write and read keep the count
  sequence s_both_taken;
    wr_acc && rd_acc && !clr;
  endsequence

  chk_level_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_both_taken |=> fill_level_o == $past(fill_level_o))
    else $error("fill level moved on write plus read");

  // an unmasked event raises the line one edge later unless mask moves
  chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bus_wr && (ev & imsk_r) != '0) |=> irq_o)
    else $error("unmasked event raised no interrupt");

  // reading status leaves only the events of that same edge
  chk_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_rd && adr_i == `FFLG_OFS_IRQ_ST) |=> ist_r == $past(ev))
    else $error("status not cleared by read");
endmodule // fflg_top
`default_nettype wire

// ===== fflg_user_model.sv
`default_nettype none
// ---------------------------------------------------------------
// user logic on the far side: writer and reader of fifo words
// ---------------------------------------------------------------
module fflg_user_model (
  input  wire logic clk_i,
  input  wire logic want_wr_i,
  input  wire logic want_rd_i,
  input  wire logic rude_i,
  input  wire logic empty_i,
  input  wire logic rd_word_i,
  output logic      wr_req_o,
  output logic      rd_req_o,
  output var int    words_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // reader holds off while empty; rude_i breaks that to probe refusal
  assign rd_req_o = want_rd_i & (~empty_i | rude_i);
  assign wr_req_o = want_wr_i;
  // count every word handed over
  initial words_o = 0;
  always @(posedge clk_i) begin
    if (rd_word_i === 1'b1) words_o <= words_o + 1;
  end
endmodule // fflg_user_model
`default_nettype wire

// ===== fifo_flag_logic_bench.sv
`default_nettype none
module fifo_flag_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_i, cyc, stb, we, clr, wwr, wrd, rude;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q;
  logic        ack, wr_req, rd_req, rd_word, full, empty, nfull, nempty, irq;
  logic [15:0] level;
  int          words;
  int          n_mismatch = 0;
  int          checked = 0;
  // ---------------------------------------------------------------
  // design and far-side model; small capacity keeps the full test short
  // ---------------------------------------------------------------
  fflg_top #(.CAP(300)) u_fflg_top (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .fifo_clear_in_i(clr),
    .wr_req_i(wr_req), .rd_req_i(rd_req), .rd_word_o(rd_word),
    .full_o(full), .empty_o(empty), .near_full_status_o(nfull),
    .near_empty_status_o(nempty), .fill_level_o(level), .irq_o(irq));
  fflg_user_model u_fflg_user_model (.clk_i(clk_i), .want_wr_i(wwr),
    .want_rd_i(wrd), .rude_i(rude), .empty_i(empty),
    .rd_word_i(rd_word), .wr_req_o(wr_req), .rd_req_o(rd_req),
    .words_o(words));
  // clock at 40 MHz
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // single compare point
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // stream n cycles of write and/or read requests
  task automatic run(input int n, input logic w, input logic r);
    @(posedge clk_i);
    wwr <= w; wrd <= r;
    repeat (n) @(posedge clk_i);
    wwr <= 1'b0; wrd <= 1'b0;
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk({full, empty, nfull, nempty, irq}, 5'b01010);
    chk(level, 16'h0000);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_refuse;
    rude = 1'b1;
    run(3, 1'b0, 1'b1);
    rude = 1'b0;
    #25 chk(words, 0);
    chk(level, 16'h0000);
  endtask
  task automatic t_marks;
    wb(1'b1, 8'h14, 32'h40);
    wb(1'b1, 8'h00, 32'h0100);
    run(1, 1'b1, 1'b0);
    chk({nempty, empty}, 2'b00);
    run(254, 1'b1, 1'b0);
    chk({level, nfull}, {16'd255, 1'b0});
    run(1, 1'b1, 1'b0);
    chk(nfull, 1'b1);
    wb(1'b1, 8'h00, 32'h0110);
    repeat (2) @(posedge clk_i);
    #1 chk(nempty, 1'b1);
    wb(1'b1, 8'h14, 32'h00);
    repeat (2) @(posedge clk_i);
    #1 chk(nempty, 1'b0);
  endtask
  task automatic t_full;
    run(46, 1'b1, 1'b0);
    chk({level, full}, {16'd300, 1'b1});
  endtask
  task automatic t_drain;
    run(1, 1'b1, 1'b1);
    chk(level, 16'd299);
    run(1, 1'b1, 1'b1);
    chk(level, 16'd299);
    run(305, 1'b0, 1'b1);
    #25 chk(words, 301);
    chk({level, empty}, {16'd0, 1'b1});
  endtask
  task automatic t_irq;
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b0, 8'h0c, 32'h0);
    run(5, 1'b1, 1'b0);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    #1 chk({full, empty, nfull, nempty}, 4'b0101);
    chk(level, 16'h0);
    repeat (2) @(posedge clk_i);
    #1 chk(irq, 1'b1);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q & 32'h2, 32'h2);
    repeat (2) @(posedge clk_i);
    #1 chk(irq, 1'b0);
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  // main sequence: 5 cycles of reset, then each scenario in turn
  initial begin
    {rst_i, cyc, stb, we, clr, wwr, wrd, rude} = 8'h80;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_refuse();
    t_marks();
    t_full();
    t_drain();
    t_irq();
    give_verdict();
  end
endmodule // fifo_flag_logic_bench
`default_nettype wire
